//--- pef_pkg.sv
// Shared constants of the peripheral event flag block and its rollover detector
package pef_pkg;
  localparam int PEF_DATA_W = 8;
  localparam logic [7:0] PEF_FLAGS_INDEX = 8'h16;
  localparam logic [7:0] PEF_MASK_INDEX = 8'h17;
  localparam logic [31:0] PEF_FLAGS_ADDR = {22'h00_0000, PEF_FLAGS_INDEX, 2'b00};
  localparam logic [31:0] PEF_MASK_ADDR = {22'h00_0000, PEF_MASK_INDEX, 2'b00};
  localparam int PEF_BIT_PORT = 7;
  localparam int PEF_BIT_TMR3 = 6;
  localparam int PEF_BIT_TMR2 = 5;
  localparam int PEF_BIT_TMR1 = 4;
  localparam int PEF_BIT_CAP2 = 3;
  localparam int PEF_BIT_CAP1 = 2;
  localparam int PEF_BIT_TX = 1;
  localparam int PEF_BIT_RX = 0;
  localparam int PEF_STICKY_LSB = 2;
  localparam logic [5:0] PEF_STICKY_RESET = 6'h00;
  localparam logic [7:0] PEF_MASK_RESET = 8'h00;
  localparam logic [7:0] PEF_ROLL_TARGET = 8'h00;
endpackage : pef_pkg

//--- pef_rollover.sv
// Detects a counter stepping from its target value to zero
`timescale 1ns/1ns
`default_nettype none
module pef_rollover
  import pef_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] count,
  input wire logic [W-1:0] period,
  input wire logic wrap_mode,
  output logic rolled
);
  logic matched_ff;
  logic nxt_matched;
  logic [W-1:0] target;

  if (W < 1) begin : g_bad_width
    $error("pef_rollover width must be at least one bit");
  end

  always_comb begin
    // Wrap mode looks for all ones, so overflow and period match share one detector
    target = wrap_mode ? {W{1'b1}} : period;
    nxt_matched = (count == target);
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      matched_ff <= 1'b0;
    end else begin
      matched_ff <= nxt_matched;
    end
  end

  assign rolled = matched_ff && (count == '0);
endmodule : pef_rollover
`default_nettype wire

//--- pef_flags.sv
// Peripheral event flag register with APB access and masked interrupt
//
// Behaviour
// - Flags set regardless of enables or global disable
// - Flag register at index 16h, eight bits
// - Bit 7 set on port mismatch
// - Bit 6 on third timer overflow when capture
// - Bit 6 on third timer period rollover otherwise
// - Bit 5 on second timer period rollover
// - Bit 4 on first timer rollover, eight-bit
// - Bit 4 on combined timer rollover, sixteen-bit
// - Bit 3 on second capture event
// - Bit 2 on first capture event
// - Bit 1 shows transmit buffer empty
// - Bit 0 shows receive buffer full
// - Bits 1,0 read-only; upper bits writable, reset 0
//
// Local design decision: register access over APB.
`timescale 1ns/1ns
`default_nettype none
module pef_flags
  import pef_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] change_monitored_port,
  input wire logic [7:0] port_latch_value,
  input wire logic [7:0] first_timer_count,
  input wire logic [7:0] second_timer_count,
  input wire logic [15:0] third_timer_count,
  input wire logic [7:0] first_timer_period,
  input wire logic [7:0] second_timer_period,
  input wire logic [15:0] third_timer_period_pair,
  input wire logic timer_width_select,
  input wire logic capture_or_period_select,
  input wire logic first_capture_event,
  input wire logic second_capture_event,
  input wire logic serial_tx_empty_flag,
  input wire logic serial_rx_full_flag,
  input wire logic global_irq_disable,
  output logic irq
);
  logic [7:2] sticky_ff;
  logic [7:2] nxt_sticky;
  logic [7:0] mask_ff;
  logic [7:0] nxt_mask;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic slverr_ff;
  logic nxt_slverr;
  logic [7:2] set_evt;
  logic [7:0] flags_view;
  logic setup_phase;
  logic access_wr;
  logic roll_t1_8;
  logic roll_t1_16;
  logic roll_t2;
  logic roll_t3;

  function automatic logic addr_known(input logic [31:0] a);
    return (a == PEF_FLAGS_ADDR) || (a == PEF_MASK_ADDR);
  endfunction : addr_known

  pef_rollover #(.W(8)) u_roll_t1_8 (
    .clk(clk),
    .rst_b(rst_b),
    .count(first_timer_count),
    .period(first_timer_period),
    .wrap_mode(1'b0),
    .rolled(roll_t1_8)
  );

  // Combined count keeps the first timer in the upper byte
  pef_rollover #(.W(16)) u_roll_t1_16 (
    .clk(clk),
    .rst_b(rst_b),
    .count({first_timer_count, second_timer_count}),
    .period({first_timer_period, second_timer_period}),
    .wrap_mode(1'b0),
    .rolled(roll_t1_16)
  );

  pef_rollover #(.W(8)) u_roll_t2 (
    .clk(clk),
    .rst_b(rst_b),
    .count(second_timer_count),
    .period(second_timer_period),
    .wrap_mode(1'b0),
    .rolled(roll_t2)
  );

  // Capture mode frees the period pair, so the third timer wraps at all ones
  pef_rollover #(.W(16)) u_roll_t3 (
    .clk(clk),
    .rst_b(rst_b),
    .count(third_timer_count),
    .period(third_timer_period_pair),
    .wrap_mode(capture_or_period_select),
    .rolled(roll_t3)
  );

  always_comb begin
    // No enable or global disable term here on purpose
    set_evt = '0;
    set_evt[PEF_BIT_PORT] = (change_monitored_port != port_latch_value);
    set_evt[PEF_BIT_TMR3] = roll_t3;
    set_evt[PEF_BIT_TMR2] = roll_t2;
    set_evt[PEF_BIT_TMR1] = timer_width_select ? roll_t1_16 : roll_t1_8;
    set_evt[PEF_BIT_CAP2] = second_capture_event;
    set_evt[PEF_BIT_CAP1] = first_capture_event;
  end

  always_comb begin
    flags_view = {sticky_ff, serial_tx_empty_flag, serial_rx_full_flag};
  end

  assign setup_phase = psel && !penable;
  assign access_wr = psel && penable && pwrite;

  always_comb begin
    nxt_sticky = sticky_ff;
    nxt_mask = mask_ff;
    if (access_wr && (paddr == PEF_FLAGS_ADDR)) begin
      nxt_sticky = pwdata[7:2];
    end
    if (access_wr && (paddr == PEF_MASK_ADDR)) begin
      nxt_mask = pwdata[7:0];
    end
    // A source event in the clearing cycle wins over the write
    nxt_sticky = nxt_sticky | set_evt;
  end

  always_comb begin
    nxt_prdata = prdata_ff;
    nxt_slverr = slverr_ff;
    if (setup_phase) begin
      nxt_slverr = !addr_known(paddr);
      nxt_prdata = '0;
      if (paddr == PEF_FLAGS_ADDR) begin
        nxt_prdata = {24'h00_0000, flags_view};
      end else if (paddr == PEF_MASK_ADDR) begin
        nxt_prdata = {24'h00_0000, mask_ff};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sticky_ff <= PEF_STICKY_RESET;
      mask_ff <= PEF_MASK_RESET;
      prdata_ff <= '0;
      slverr_ff <= 1'b0;
    end else begin
      sticky_ff <= nxt_sticky;
      mask_ff <= nxt_mask;
      prdata_ff <= nxt_prdata;
      slverr_ff <= nxt_slverr;
    end
  end

  // Read data is caught in the setup cycle, so every access ends without wait states
  assign pready = 1'b1;
  assign prdata = prdata_ff;
  assign pslverr = psel && penable && slverr_ff;
  assign irq = !global_irq_disable && |(flags_view & mask_ff);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_port_sets: assert property ((change_monitored_port != port_latch_value) |=> sticky_ff[PEF_BIT_PORT])
    else $error("port mismatch did not set its flag");
  a_capture_one: assert property (first_capture_event |=> sticky_ff[PEF_BIT_CAP1])
    else $error("first capture did not set its flag");
  a_capture_two: assert property (second_capture_event |=> sticky_ff[PEF_BIT_CAP2])
    else $error("second capture did not set its flag");
  a_ignore_disable: assert property ((global_irq_disable && first_capture_event) |=> flags_view[PEF_BIT_CAP1])
    else $error("flag blocked by global disable");
  a_t3_overflow: assert property ((capture_or_period_select && third_timer_count == 16'hFFFF
      && $stable(capture_or_period_select)) ##1 (third_timer_count == 16'h0000) |=> sticky_ff[PEF_BIT_TMR3])
    else $error("third timer overflow missed");
  a_t3_period: assert property ((!capture_or_period_select && third_timer_count == third_timer_period_pair)
      ##1 (!capture_or_period_select && third_timer_count == 16'h0000) |=> sticky_ff[PEF_BIT_TMR3])
    else $error("third timer period rollover missed");
  a_t2_period: assert property ((second_timer_count == second_timer_period)
      ##1 (second_timer_count == 8'h00) |=> sticky_ff[PEF_BIT_TMR2])
    else $error("second timer rollover missed");
  a_t1_eight: assert property ((!timer_width_select && first_timer_count == first_timer_period)
      ##1 (!timer_width_select && first_timer_count == 8'h00) |=> sticky_ff[PEF_BIT_TMR1])
    else $error("first timer eight-bit rollover missed");
  a_t1_sixteen: assert property ((timer_width_select && {first_timer_count, second_timer_count}
      == {first_timer_period, second_timer_period}) ##1 (timer_width_select
      && {first_timer_count, second_timer_count} == 16'h0000) |=> sticky_ff[PEF_BIT_TMR1])
    else $error("combined timer rollover missed");
  a_serial_view: assert property (flags_view[1:0] == {serial_tx_empty_flag, serial_rx_full_flag})
    else $error("serial flags do not follow buffers");
  a_read_flags: assert property ((setup_phase && !pwrite && paddr == PEF_FLAGS_ADDR)
      |=> prdata == {24'h00_0000, $past(flags_view)})
    else $error("flag read returned wrong value");
  a_sticky_hold: assert property ((sticky_ff[PEF_BIT_CAP1] && !(access_wr && paddr == PEF_FLAGS_ADDR))
      |=> sticky_ff[PEF_BIT_CAP1])
    else $error("sticky flag dropped without a write");
  a_clear_zero: assert property ((access_wr && paddr == PEF_FLAGS_ADDR && !pwdata[PEF_BIT_CAP2]
      && !second_capture_event) |=> !sticky_ff[PEF_BIT_CAP2])
    else $error("write of zero did not clear flag");
  a_irq_level: assert property (irq == (!global_irq_disable && |(flags_view & mask_ff)))
    else $error("interrupt output disagrees with masked flags");

  // Register bus checks; the master must hold address from setup into access
  a_mask_write: assert property ((access_wr && paddr == PEF_MASK_ADDR)
      |=> mask_ff == $past(pwdata[7:0]))
    else $error("mask write did not land");
  a_mask_hold: assert property (!(access_wr && paddr == PEF_MASK_ADDR)
      |=> mask_ff == $past(mask_ff))
    else $error("mask changed without a write");
  a_ready_high: assert property ((psel && penable)
      |-> pready)
    else $error("access phase without ready");
  a_err_unmapped: assert property ((psel && penable && !addr_known(paddr))
      |-> pslverr)
    else $error("unmapped access not refused");
  a_err_mapped: assert property ((psel && penable && addr_known(paddr))
      |-> !pslverr)
    else $error("mapped access flagged as error");
  a_err_idle: assert property (!(psel && penable)
      |-> !pslverr)
    else $error("error response outside access phase");
  a_read_mask: assert property ((setup_phase && paddr == PEF_MASK_ADDR)
      |=> prdata == {24'h00_0000, $past(mask_ff)})
    else $error("mask read returned wrong value");
  a_read_unmapped: assert property ((setup_phase && !addr_known(paddr))
      |=> prdata == 32'h0000_0000)
    else $error("unmapped read returned data");
  a_prdata_hold: assert property (!setup_phase
      |=> prdata == $past(prdata))
    else $error("read data moved outside setup");
  a_upper_zero: assert property (prdata[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");

  // Flag register write and serial view checks
  a_write_sets: assert property ((access_wr && paddr == PEF_FLAGS_ADDR && pwdata[PEF_BIT_PORT])
      |=> sticky_ff[PEF_BIT_PORT])
    else $error("write of one did not set flag");
  a_port_clear: assert property ((access_wr && paddr == PEF_FLAGS_ADDR && !pwdata[PEF_BIT_PORT]
      && change_monitored_port == port_latch_value) |=> !sticky_ff[PEF_BIT_PORT])
    else $error("port flag not cleared after mismatch ended");
  a_timer_clear: assert property ((access_wr && paddr == PEF_FLAGS_ADDR && !pwdata[PEF_BIT_TMR2]
      && !roll_t2) |=> !sticky_ff[PEF_BIT_TMR2])
    else $error("timer flag not cleared by zero write");
  a_cap_clear: assert property ((access_wr && paddr == PEF_FLAGS_ADDR && !pwdata[PEF_BIT_CAP1]
      && !first_capture_event) |=> !sticky_ff[PEF_BIT_CAP1])
    else $error("capture flag not cleared by zero write");
  a_flags_keep: assert property ((!(access_wr && paddr == PEF_FLAGS_ADDR) && set_evt == '0)
      |=> sticky_ff == $past(sticky_ff))
    else $error("flags moved without write or event");
  a_tx_view: assert property (flags_view[PEF_BIT_TX] == serial_tx_empty_flag)
    else $error("transmit flag does not follow buffer");
  a_rx_view: assert property (flags_view[PEF_BIT_RX] == serial_rx_full_flag)
    else $error("receive flag does not follow buffer");

  // Event source and interrupt checks
  a_t2_roll: assert property (roll_t2
      |=> sticky_ff[PEF_BIT_TMR2])
    else $error("second timer rollover not latched");
  a_t3_roll: assert property (roll_t3
      |=> sticky_ff[PEF_BIT_TMR3])
    else $error("third timer rollover not latched");
  a_t1_narrow: assert property ((!timer_width_select && roll_t1_8)
      |=> sticky_ff[PEF_BIT_TMR1])
    else $error("eight-bit rollover not latched");
  a_t1_wide: assert property ((timer_width_select && roll_t1_16)
      |=> sticky_ff[PEF_BIT_TMR1])
    else $error("combined rollover not latched");
  a_t1_narrow_quiet: assert property ((!timer_width_select && !roll_t1_8)
      |-> !set_evt[PEF_BIT_TMR1])
    else $error("first timer flag set without eight-bit rollover");
  a_t1_wide_quiet: assert property ((timer_width_select && !roll_t1_16)
      |-> !set_evt[PEF_BIT_TMR1])
    else $error("first timer flag set without combined rollover");
  a_irq_disable: assert property (global_irq_disable
      |-> !irq)
    else $error("interrupt raised while globally disabled");
  a_irq_masked: assert property ((mask_ff == 8'h00)
      |-> !irq)
    else $error("interrupt raised with every source masked");

  c_irq_rise: cover property ($rose(irq));
  c_flag_clear: cover property (access_wr && paddr == PEF_FLAGS_ADDR ##1 !sticky_ff[PEF_BIT_PORT]);
  c_t1_wide: cover property (timer_width_select && roll_t1_16);
  c_bad_addr: cover property (pslverr);
  c_t3_capture: cover property (capture_or_period_select && roll_t3);
endmodule : pef_flags
`default_nettype wire

//--- pef_testbench.sv
// Self-checking bench for the peripheral event flag block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import pef_pkg::*;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [31:0] paddr, pwdata, prdata, lfsr_v, rd;
  logic [7:0] change_monitored_port, port_latch_value, first_timer_count, second_timer_count;
  logic [7:0] first_timer_period, second_timer_period;
  logic [15:0] third_timer_count, third_timer_period_pair;
  logic timer_width_select, capture_or_period_select, first_capture_event, second_capture_event;
  logic serial_tx_empty_flag, serial_rx_full_flag, global_irq_disable;
  int n_mismatch, checked, m_flags, m_mask;
  pef_flags pef_flags_inst (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .change_monitored_port, .port_latch_value, .first_timer_count, .second_timer_count,
    .third_timer_count, .first_timer_period, .second_timer_period, .third_timer_period_pair,
    .timer_width_select, .capture_or_period_select, .first_capture_event, .second_capture_event,
    .serial_tx_empty_flag, .serial_rx_full_flag, .global_irq_disable, .irq);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic test_done();
    if (n_mismatch == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done
  initial begin
    #300000;
    n_mismatch++;
    test_done();
  end
  task automatic rnd();
    lfsr_v = {lfsr_v[30:0], lfsr_v[31] ^ lfsr_v[21] ^ lfsr_v[1] ^ lfsr_v[0]};
  endtask : rnd
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Request held from setup until pready is seen high at an edge
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic check_regs();
    logic [7:0] e;
    e = {m_flags[5:0], serial_tx_empty_flag, serial_rx_full_flag};
    @(negedge clk);
    chk({31'h0, irq}, {31'h0, !global_irq_disable && |(e & m_mask[7:0])});
    chk({31'h0, pready}, 32'h0000_0001);
    apb(1'b0, PEF_FLAGS_ADDR, 32'h0, rd);
    chk(rd, {24'h00_0000, e});
  endtask : check_regs
  task automatic wr_flags(input logic [7:0] v);
    apb(1'b1, PEF_FLAGS_ADDR, {24'h00_0000, v}, rd);
    m_flags = v[7:2];
  endtask : wr_flags
  // Kinds: 0 eight-bit first, 1 combined, 2 second, 3 overflow, 4 period pair, 5 pair while capturing
  task automatic roll(input int k);
    timer_width_select <= (k == 1);
    capture_or_period_select <= (k == 3 || k == 5);
    @(posedge clk);
    first_timer_count <= (k < 2) ? first_timer_period : 8'h01;
    second_timer_count <= (k == 1 || k == 2) ? second_timer_period : 8'h01;
    third_timer_count <= (k == 3) ? 16'hFFFF : (k > 3) ? third_timer_period_pair : 16'h0001;
    @(posedge clk);
    {first_timer_count, second_timer_count, third_timer_count} <= '0;
    @(posedge clk);
    {first_timer_count, second_timer_count, third_timer_count} <= {8'h01, 8'h01, 16'h0001};
    m_flags = m_flags | {(k == 3 || k == 4), (k == 1 || k == 2), (k < 2), 2'b00};
  endtask : roll
  initial begin
    {psel, penable, pwrite, paddr, pwdata, first_capture_event, second_capture_event} = '0;
    {change_monitored_port, port_latch_value, timer_width_select, capture_or_period_select} = '0;
    {first_timer_count, second_timer_count, third_timer_count} = {8'h01, 8'h01, 16'h0001};
    {serial_tx_empty_flag, serial_rx_full_flag, global_irq_disable, rst_b} = 4'b1010;
    {n_mismatch, checked, m_flags, m_mask} = '0;
    lfsr_v = 32'h0001_858E;
    rnd();
    first_timer_period = lfsr_v[7:0] | 8'h80;
    second_timer_period = lfsr_v[15:8] | 8'h80;
    third_timer_period_pair = (lfsr_v[31:16] & 16'h7FFF) | 16'h4000;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    check_regs();
    apb(1'b0, PEF_MASK_ADDR, 32'h0, rd);
    chk(rd, 32'h0000_0000);
    apb(1'b1, 32'h0000_0040, 32'h0000_00FF, rd);
    apb(1'b0, 32'h0000_0040, 32'h0, rd);
    chk({rd[30:0], err}, 32'h0000_0001);
    check_regs();
    global_irq_disable <= 1'b1;
    first_capture_event <= 1'b1;
    @(posedge clk);
    first_capture_event <= 1'b0;
    second_capture_event <= 1'b1;
    @(posedge clk);
    second_capture_event <= 1'b0;
    m_flags = 3;
    check_regs();
    rnd();
    change_monitored_port <= lfsr_v[7:0] | 8'h01;
    @(posedge clk);
    port_latch_value <= lfsr_v[7:0] | 8'h01;
    m_flags = m_flags | 32;
    check_regs();
    wr_flags(8'h00);
    check_regs();
    for (int k = 0; k < 6; k++) begin
      roll(k);
      check_regs();
      wr_flags(8'h00);
    end
    for (int i = 0; i < 4; i++) begin
      rnd();
      {serial_tx_empty_flag, serial_rx_full_flag} <= lfsr_v[1:0];
      wr_flags(lfsr_v[9:2]);
      check_regs();
    end
    // Stale flag cleared before its enable goes on
    wr_flags(8'h00);
    apb(1'b1, PEF_MASK_ADDR, 32'h0000_0005, rd);
    m_mask = 5;
    apb(1'b0, PEF_MASK_ADDR, 32'h0, rd);
    chk(rd, 32'h0000_0005);
    global_irq_disable <= 1'b0;
    check_regs();
    first_capture_event <= 1'b1;
    @(posedge clk);
    first_capture_event <= 1'b0;
    m_flags = 1;
    check_regs();
    global_irq_disable <= 1'b1;
    check_regs();
    test_done();
  end
endmodule : testbench
`default_nettype wire
